// ### rtl/phy_irq_pkg.sv
/*
  Shared constants and types of the interrupt clear, output control and
  event-count threshold block of a gigabit Ethernet transceiver.
  Assumes a 125 MHz core clock and a 32-bit Avalon-MM register slave.
*/
package phy_irq_pkg;

  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 18;
  localparam int DATA_W = 32;
  localparam int REG_W  = 8;
  localparam int CNT_N  = 4;

  // ----------------------------------------------------------------
  // Register indices; byte address is index times four
  // ----------------------------------------------------------------
  localparam logic [15:0] IDX_ENABLE_LOW   = 16'h8113;
  localparam logic [15:0] IDX_ENABLE_HIGH  = 16'h8114;
  localparam logic [15:0] IDX_CLEAR_LOW    = 16'h8115;
  localparam logic [15:0] IDX_CLEAR_HIGH   = 16'h8116;
  localparam logic [15:0] IDX_OUT_CONTROL  = 16'h8117;
  localparam logic [15:0] IDX_NEG_LIMIT    = 16'h8118;
  localparam logic [15:0] IDX_LINK_LIMIT   = 16'h8119;
  localparam logic [15:0] IDX_IDLE_LIMIT   = 16'h811A;
  localparam logic [15:0] IDX_STATUS_LOW   = 16'h8120;
  localparam logic [15:0] IDX_STATUS_HIGH  = 16'h8121;
  localparam logic [15:0] IDX_NEG_COUNT    = 16'h8122;
  localparam logic [15:0] IDX_LINK10_COUNT = 16'h8123;
  localparam logic [15:0] IDX_LINK1K_COUNT = 16'h8124;
  localparam logic [15:0] IDX_IDLE_COUNT   = 16'h8125;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int BIT_NEG_COUNT  = 7;
  localparam int BIT_NEG_DONE   = 6;
  localparam int BIT_FAR_FAULT  = 5;
  localparam int BIT_SPEED      = 4;
  localparam int BIT_LINK_COUNT = 3;
  localparam int BIT_LINK       = 2;
  localparam int BIT_DUPLEX     = 1;
  localparam int BIT_JABBER     = 0;
  localparam int BIT_CONFIG     = 6;
  localparam int BIT_LOCAL_RX   = 5;
  localparam int BIT_REMOTE_RX  = 4;
  localparam int BIT_IDLE_COUNT = 3;
  localparam int BIT_RESET_EVT  = 0;
  localparam int BIT_OUT_ENABLE = 2;
  localparam int BIT_POLARITY   = 0;

  localparam logic [7:0] HIGH_USED_MASK = 8'h79;
  localparam logic [7:0] REG_ZERO       = 8'h00;
  localparam logic [7:0] LIMIT_RESET    = 8'hFF;

  // Counter slots of the threshold bank
  localparam int CNT_NEG    = 0;
  localparam int CNT_LINK10 = 1;
  localparam int CNT_LINK1K = 2;
  localparam int CNT_IDLE   = 3;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic negotiation_done;
    logic far_fault;
    logic speed_change;
    logic link_change;
    logic duplex_change;
    logic jabber;
    logic config_change;
    logic local_rx_change;
    logic remote_rx_change;
    logic reset_event;
    logic negotiation_tick;
    logic link10_tick;
    logic link1000_tick;
    logic idle_error_tick;
  } irq_events_t;

  typedef struct packed {
    logic [ADDR_W-1:0] address;
    logic              read;
    logic              write;
    logic [3:0]        byteenable;
    logic [DATA_W-1:0] writedata;
  } avs_req_t;

endpackage : phy_irq_pkg

// ### rtl/threshold_counter.sv
/*
  One saturating event counter with a clear and a programmable limit.
  Assumes single-cycle event ticks in the core clock domain.
*/
`timescale 1ns/100ps
`default_nettype none
module threshold_counter
  import phy_irq_pkg::*;
#(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  // Event and control
  input  wire logic         i_tick,
  input  wire logic         i_clear,
  input  wire logic [W-1:0] i_limit,
  // State
  output logic      [W-1:0] o_count,
  output logic              o_hit
);

  logic [W-1:0] next_count;

  // A tick in the clearing cycle counts as the first event of the new run
  always_comb begin
    if (i_clear) begin
      next_count = i_tick ? W'(1) : '0;
    end else if (i_tick && (o_count != {W{1'b1}})) begin
      next_count = o_count + W'(1);
    end else begin
      next_count = o_count;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_count <= '0;
    end else begin
      o_count <= next_count;
    end
  end

  // Only a counted event can land on the limit, so a bare clear or a zero limit never fires
  assign o_hit = i_tick && (next_count == i_limit) &&
                 (i_clear || (o_count != {W{1'b1}}));

  hit_on_limit_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_hit |=> (o_count == $past(i_limit))) else $error("hit without limit reached");

endmodule : threshold_counter
`default_nettype wire

// ### rtl/phy_irq_ctrl.sv
/*
  Interrupt status, clear, output control and threshold registers.
  Assumes event inputs are one-cycle pulses in the I_SYS_CLK domain and
  an Avalon-MM master that holds each request until waitrequest is low.
*/
`timescale 1ns/100ps
`default_nettype none
module phy_irq_ctrl
  import phy_irq_pkg::*;
(
  // Clock and reset
  input  wire logic              I_SYS_CLK,
  input  wire logic              I_RST_N,
  // Avalon-MM slave
  input  wire logic [ADDR_W-1:0] i_AVS_ADDRESS,
  input  wire logic              i_AVS_READ,
  input  wire logic              i_AVS_WRITE,
  input  wire logic [3:0]        i_AVS_BYTEENABLE,
  input  wire logic [DATA_W-1:0] i_AVS_WRITEDATA,
  output logic      [DATA_W-1:0] o_AVS_READDATA,
  output logic                   o_AVS_WAITREQUEST,
  // Event sources
  input  wire irq_events_t       i_EVENTS,
  input  wire logic              i_LED_PINS_ENABLED,
  // Interrupt pin
  output logic                   o_IRQ_PIN,
  output logic                   o_IRQ_PIN_OE_N,
  output logic                   o_IRQ_PENDING
);

  // ----------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------
  avs_req_t          req;
  logic              ack;
  logic [15:0]       idx;
  logic              wr_go;
  logic              wr_lane;
  logic [REG_W-1:0]  wbyte;

  assign req = '{address: i_AVS_ADDRESS, read: i_AVS_READ, write: i_AVS_WRITE,
                 byteenable: i_AVS_BYTEENABLE, writedata: i_AVS_WRITEDATA};
  assign idx   = 16'(req.address[ADDR_W-1:2]);
  assign wbyte = req.writedata[REG_W-1:0];

  // One wait cycle gives the read mux a full cycle before data is due
  assign o_AVS_WAITREQUEST = (req.read || req.write) && !ack;
  assign wr_lane           = req.byteenable[0];
  assign wr_go             = req.write && ack && wr_lane;

  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      ack <= 1'b0;
    end else begin
      ack <= (req.read || req.write) && !ack;
    end
  end

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  logic [REG_W-1:0] enable_low;
  logic [REG_W-1:0] enable_high;
  logic [REG_W-1:0] out_control;
  logic [REG_W-1:0] negotiation_count_limit;
  logic [REG_W-1:0] link_event_limit;
  logic [REG_W-1:0] idle_error_limit;

  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      enable_low              <= REG_ZERO;
      enable_high             <= REG_ZERO;
      out_control             <= REG_ZERO;
      negotiation_count_limit <= LIMIT_RESET;
      link_event_limit        <= LIMIT_RESET;
      idle_error_limit        <= LIMIT_RESET;
    end else if (wr_go) begin
      case (idx)
        IDX_ENABLE_LOW:  enable_low              <= wbyte;
        IDX_ENABLE_HIGH: enable_high             <= wbyte & HIGH_USED_MASK;
        IDX_OUT_CONTROL: out_control             <= wbyte;
        IDX_NEG_LIMIT:   negotiation_count_limit <= wbyte;
        IDX_LINK_LIMIT:  link_event_limit        <= wbyte;
        IDX_IDLE_LIMIT:  idle_error_limit        <= wbyte;
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Self-clearing clear commands
  // ----------------------------------------------------------------
  logic [REG_W-1:0] interrupt_clear_low;
  logic [REG_W-1:0] interrupt_clear_high;
  logic [REG_W-1:0] next_clear_low;
  logic [REG_W-1:0] next_clear_high;

  // A written one acts in the cycle after acceptance, then drops to zero
  always_comb begin
    next_clear_low  = REG_ZERO;
    next_clear_high = REG_ZERO;
    if (wr_go && (idx == IDX_CLEAR_LOW)) begin
      next_clear_low = wbyte;
    end
    if (wr_go && (idx == IDX_CLEAR_HIGH)) begin
      next_clear_high = wbyte & HIGH_USED_MASK;
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      interrupt_clear_low  <= REG_ZERO;
      interrupt_clear_high <= REG_ZERO;
    end else begin
      interrupt_clear_low  <= next_clear_low;
      interrupt_clear_high <= next_clear_high;
    end
  end

  // Status write-one-to-clear, folded in with the clear commands
  logic [REG_W-1:0] w1c_low;
  logic [REG_W-1:0] w1c_high;

  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      w1c_low  <= REG_ZERO;
      w1c_high <= REG_ZERO;
    end else begin
      w1c_low  <= (wr_go && (idx == IDX_STATUS_LOW))  ? wbyte : REG_ZERO;
      w1c_high <= (wr_go && (idx == IDX_STATUS_HIGH)) ? wbyte : REG_ZERO;
    end
  end

  logic [REG_W-1:0] kill_low;
  logic [REG_W-1:0] kill_high;
  assign kill_low  = interrupt_clear_low | w1c_low;
  assign kill_high = (interrupt_clear_high | w1c_high) & HIGH_USED_MASK;

  // ----------------------------------------------------------------
  // Threshold counter bank
  // ----------------------------------------------------------------
  logic [CNT_N-1:0]            cnt_tick;
  logic [CNT_N-1:0]            cnt_clear;
  logic [CNT_N-1:0]            cnt_hit;
  logic [CNT_N-1:0][REG_W-1:0] cnt_limit;
  logic [CNT_N-1:0][REG_W-1:0] cnt_value;

  assign cnt_tick  = {i_EVENTS.idle_error_tick, i_EVENTS.link1000_tick,
                      i_EVENTS.link10_tick, i_EVENTS.negotiation_tick};
  // Idle-error counter has no clear command; it only saturates
  assign cnt_clear = {1'b0,
                      interrupt_clear_low[BIT_LINK_COUNT],
                      interrupt_clear_low[BIT_LINK_COUNT],
                      interrupt_clear_low[BIT_NEG_COUNT]};
  assign cnt_limit = {idle_error_limit, link_event_limit,
                      link_event_limit, negotiation_count_limit};

  genvar gi;
  generate
    for (gi = 0; gi < CNT_N; gi++) begin : g_cnt
      threshold_counter #(.W(REG_W)) u_cnt (
        .i_clk   (I_SYS_CLK),
        .i_rst_n (I_RST_N),
        .i_tick  (cnt_tick[gi]),
        .i_clear (cnt_clear[gi]),
        .i_limit (cnt_limit[gi]),
        .o_count (cnt_value[gi]),
        .o_hit   (cnt_hit[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Sticky status
  // ----------------------------------------------------------------
  logic [REG_W-1:0] set_low;
  logic [REG_W-1:0] set_high;
  logic [REG_W-1:0] status_low;
  logic [REG_W-1:0] status_high;
  logic             negotiation_count_irq_status;

  always_comb begin
    set_low                 = REG_ZERO;
    set_low[BIT_NEG_COUNT]  = cnt_hit[CNT_NEG];
    set_low[BIT_NEG_DONE]   = i_EVENTS.negotiation_done;
    set_low[BIT_FAR_FAULT]  = i_EVENTS.far_fault;
    set_low[BIT_SPEED]      = i_EVENTS.speed_change;
    set_low[BIT_LINK_COUNT] = cnt_hit[CNT_LINK10] | cnt_hit[CNT_LINK1K];
    set_low[BIT_LINK]       = i_EVENTS.link_change;
    set_low[BIT_DUPLEX]     = i_EVENTS.duplex_change;
    set_low[BIT_JABBER]     = i_EVENTS.jabber;
    set_high                = REG_ZERO;
    set_high[BIT_CONFIG]    = i_EVENTS.config_change;
    set_high[BIT_LOCAL_RX]  = i_EVENTS.local_rx_change;
    set_high[BIT_REMOTE_RX] = i_EVENTS.remote_rx_change;
    set_high[BIT_IDLE_COUNT]= cnt_hit[CNT_IDLE];
    set_high[BIT_RESET_EVT] = i_EVENTS.reset_event;
  end

  // A new event in the clearing cycle survives the clear
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      status_low  <= REG_ZERO;
      status_high <= REG_ZERO;
    end else begin
      status_low  <= set_low | (status_low & ~kill_low);
      status_high <= set_high | (status_high & ~kill_high);
    end
  end

  assign negotiation_count_irq_status = status_low[BIT_NEG_COUNT];

  // ----------------------------------------------------------------
  // Interrupt pin
  // ----------------------------------------------------------------
  logic any_pending;
  logic pin_enabled;

  assign any_pending = |(status_low & enable_low) | |(status_high & enable_high);
  assign pin_enabled = out_control[BIT_OUT_ENABLE] && i_LED_PINS_ENABLED;

  // Pin is released, not driven inactive, while disabled
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      o_IRQ_PENDING  <= 1'b0;
      o_IRQ_PIN      <= 1'b1;
      o_IRQ_PIN_OE_N <= 1'b1;
    end else begin
      o_IRQ_PENDING  <= any_pending;
      o_IRQ_PIN      <= out_control[BIT_POLARITY] ? any_pending : !any_pending;
      o_IRQ_PIN_OE_N <= !pin_enabled;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  logic [REG_W-1:0] next_rbyte;

  always_comb begin
    case (idx)
      IDX_ENABLE_LOW:   next_rbyte = enable_low;
      IDX_ENABLE_HIGH:  next_rbyte = enable_high;
      IDX_CLEAR_LOW:    next_rbyte = interrupt_clear_low;
      IDX_CLEAR_HIGH:   next_rbyte = interrupt_clear_high;
      IDX_OUT_CONTROL:  next_rbyte = out_control;
      IDX_NEG_LIMIT:    next_rbyte = negotiation_count_limit;
      IDX_LINK_LIMIT:   next_rbyte = link_event_limit;
      IDX_IDLE_LIMIT:   next_rbyte = idle_error_limit;
      IDX_STATUS_LOW:   next_rbyte = status_low;
      IDX_STATUS_HIGH:  next_rbyte = status_high;
      IDX_NEG_COUNT:    next_rbyte = cnt_value[CNT_NEG];
      IDX_LINK10_COUNT: next_rbyte = cnt_value[CNT_LINK10];
      IDX_LINK1K_COUNT: next_rbyte = cnt_value[CNT_LINK1K];
      IDX_IDLE_COUNT:   next_rbyte = cnt_value[CNT_IDLE];
      default:          next_rbyte = REG_ZERO;
    endcase
  end

  // Captured on the wait cycle, stable at the completing edge
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      o_AVS_READDATA <= '0;
    end else if (req.read && !ack) begin
      o_AVS_READDATA <= {{(DATA_W-REG_W){1'b0}}, next_rbyte};
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence clr_write_s(logic [15:0] where, int b);
    wr_go && (idx == where) && wbyte[b];
  endsequence

  neg_count_clear_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    clr_write_s(IDX_CLEAR_LOW, BIT_NEG_COUNT) ##1 !cnt_hit[CNT_NEG]
      |=> !negotiation_count_irq_status && (cnt_value[CNT_NEG] <= 8'h01))
    else $error("negotiation count clear failed");

  link_count_clear_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    clr_write_s(IDX_CLEAR_LOW, BIT_LINK_COUNT) ##1 !(|cnt_tick[CNT_LINK1K:CNT_LINK10])
      |=> cnt_value[CNT_LINK10] == REG_ZERO && cnt_value[CNT_LINK1K] == REG_ZERO)
    else $error("link counters not cleared");

  done_clear_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    clr_write_s(IDX_CLEAR_LOW, BIT_NEG_DONE) ##1 !i_EVENTS.negotiation_done
      |=> !status_low[BIT_NEG_DONE] && interrupt_clear_low == REG_ZERO)
    else $error("low clear bit did not act or self-clear");

  config_clear_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    clr_write_s(IDX_CLEAR_HIGH, BIT_CONFIG) ##1 !i_EVENTS.config_change
      |=> !status_high[BIT_CONFIG])
    else $error("high clear bit did not act");

  pin_enable_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    ##1 (o_IRQ_PIN_OE_N == !$past(pin_enabled)))
    else $error("pin enable mismatch");

  pin_polarity_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    ##1 (o_IRQ_PIN == ($past(out_control[BIT_POLARITY]) ~^ o_IRQ_PENDING)))
    else $error("pin polarity mismatch");

  mask_gate_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    (enable_low == REG_ZERO && enable_high == REG_ZERO)[*2] |-> !o_IRQ_PENDING)
    else $error("masked source reached the pin");

  sticky_hold_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    status_low[BIT_LINK_COUNT] && !kill_low[BIT_LINK_COUNT] |=> status_low[BIT_LINK_COUNT])
    else $error("threshold status dropped without clear");

  limit_latch_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    cnt_hit[CNT_NEG] |=> negotiation_count_irq_status && cnt_value[CNT_NEG] == $past(cnt_limit[CNT_NEG]))
    else $error("negotiation limit did not latch");

  link_latch_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    (cnt_hit[CNT_LINK10] || cnt_hit[CNT_LINK1K]) |=> status_low[BIT_LINK_COUNT])
    else $error("link limit did not latch");

  idle_latch_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    cnt_hit[CNT_IDLE] |=> status_high[BIT_IDLE_COUNT])
    else $error("idle error limit did not latch");

  clear_self_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    (interrupt_clear_low != REG_ZERO) |=> (interrupt_clear_low == REG_ZERO))
    else $error("low clear command did not self-clear");

  one_wait_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    ((req.read || req.write) && !ack) |=> !o_AVS_WAITREQUEST)
    else $error("bus answer took more than one wait cycle");

endmodule : phy_irq_ctrl
`default_nettype wire

// ### tb/phy_irq_ctrl_tb.sv
/*
  Self-checking bench of the interrupt clear, output control and threshold block.
  Assumes the register indices of the package and a one-wait-state bus slave.
*/
`timescale 1ns/100ps
`default_nettype none
module phy_irq_ctrl_tb
  import phy_irq_pkg::*;
;
  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  logic              sys_clk   = 1'h0;
  logic              rst_n     = 1'h0;
  logic [ADDR_W-1:0] addr      = '0;
  logic              rd        = 1'h0;
  logic              wr        = 1'h0;
  logic [3:0]        be        = 4'hF;
  logic [DATA_W-1:0] wdata     = '0;
  logic [DATA_W-1:0] rdata;
  logic              wait_req;
  irq_events_t       ev        = '0;
  logic              led_en    = 1'h1;
  logic              irq_pin;
  logic              irq_oe_n;
  logic              irq_pend;
  int                error_cnt = 0;
  int                n_checks  = 0;
  logic [31:0]       rv;
  // Event bit in the struct and status bit it sets, low sources first
  int                evb [10]  = '{13, 12, 11, 10, 9, 8, 7, 6, 5, 4};
  int                stb [10]  = '{6, 5, 4, 2, 1, 0, 6, 5, 4, 0};

  phy_irq_ctrl uut (
    .I_SYS_CLK          (sys_clk),
    .I_RST_N            (rst_n),
    .i_AVS_ADDRESS      (addr),
    .i_AVS_READ         (rd),
    .i_AVS_WRITE        (wr),
    .i_AVS_BYTEENABLE   (be),
    .i_AVS_WRITEDATA    (wdata),
    .o_AVS_READDATA     (rdata),
    .o_AVS_WAITREQUEST  (wait_req),
    .i_EVENTS           (ev),
    .i_LED_PINS_ENABLED (led_en),
    .o_IRQ_PIN          (irq_pin),
    .o_IRQ_PIN_OE_N     (irq_oe_n),
    .o_IRQ_PENDING      (irq_pend)
  );

  initial begin
    forever #4 sys_clk = ~sys_clk;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      error_cnt++;
    end
  endtask : chk

  // Request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic [15:0] idx, input logic w, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    addr  <= {idx, 2'h0};
    rd    <= !w;
    wr    <= w;
    wdata <= {24'h000000, d};
    do begin
      @(posedge sys_clk);
      n++;
    end while (wait_req !== 1'h0 && n < 20);
    rv = rdata;
    rd <= 1'h0;
    wr <= 1'h0;
    if (wait_req !== 1'h0) begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, wait_req, 1'h0);
      error_cnt++;
      end_of_test();
    end
  endtask : bus

  task automatic wr_reg(input logic [15:0] idx, input logic [7:0] d);
    bus(idx, 1'h1, d);
  endtask : wr_reg

  task automatic rd_chk(input logic [15:0] idx, input logic [7:0] exp);
    bus(idx, 1'h0, 8'h00);
    chk(rv, {24'h000000, exp});
  endtask : rd_chk

  task automatic pulse(input int b);
    logic [13:0] v;
    v    = '0;
    v[b] = 1'h1;
    @(posedge sys_clk);
    ev <= v;
    @(posedge sys_clk);
    ev <= '0;
    repeat (3) @(posedge sys_clk);
  endtask : pulse

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    chk(irq_oe_n, 32'h1);
    rd_chk(IDX_CLEAR_LOW, 8'h00);
    rd_chk(IDX_CLEAR_HIGH, 8'h00);
    rd_chk(IDX_OUT_CONTROL, 8'h00);
    rd_chk(IDX_NEG_LIMIT, 8'hFF);
    rd_chk(IDX_LINK_LIMIT, 8'hFF);
    rd_chk(IDX_IDLE_LIMIT, 8'hFF);
    wr_reg(IDX_NEG_LIMIT, 8'h5A);
    rd_chk(IDX_NEG_LIMIT, 8'h5A);
    be <= 4'hE;
    wr_reg(IDX_NEG_LIMIT, 8'h11);
    be <= 4'hF;
    rd_chk(IDX_NEG_LIMIT, 8'h5A);
    wr_reg(16'h8130, 8'h33);
    rd_chk(16'h8130, 8'h00);
    $display("test reset done");
  endtask : t_reset

  task automatic t_status();
    logic [15:0] st;
    logic [15:0] cl;
    wr_reg(IDX_ENABLE_LOW, 8'hFF);
    wr_reg(IDX_ENABLE_HIGH, 8'hFF);
    for (int i = 0; i < 10; i++) begin
      st = (i < 6) ? IDX_STATUS_LOW : IDX_STATUS_HIGH;
      cl = (i < 6) ? IDX_CLEAR_LOW : IDX_CLEAR_HIGH;
      pulse(evb[i]);
      rd_chk(st, 8'h01 << stb[i]);
      chk(irq_pend, 32'h1);
      wr_reg(cl, 8'h00);
      rd_chk(st, 8'h01 << stb[i]);
      wr_reg(cl, 8'h01 << stb[i]);
      repeat (2) @(posedge sys_clk);
      rd_chk(st, 8'h00);
      rd_chk(cl, 8'h00);
      chk(irq_pend, 32'h0);
    end
    wr_reg(IDX_CLEAR_HIGH, 8'h86);
    rd_chk(IDX_CLEAR_HIGH, 8'h00);
    $display("test status done");
  endtask : t_status

  // Limit n, n-1 ticks stay quiet, the n-th latches, clear drops it
  task automatic t_thr(input int tb, input logic [15:0] lim, input logic [15:0] cnt,
                       input logic [15:0] st, input int sb, input logic [15:0] cl,
                       input logic [7:0] n);
    wr_reg(lim, n);
    repeat (n - 1) pulse(tb);
    rd_chk(st, 8'h00);
    pulse(tb);
    rd_chk(st, 8'h01 << sb);
    rd_chk(cnt, n);
    repeat (5) @(posedge sys_clk);
    rd_chk(st, 8'h01 << sb);
    wr_reg(cl, 8'h01 << sb);
    repeat (2) @(posedge sys_clk);
    rd_chk(st, 8'h00);
  endtask : t_thr

  task automatic t_counts();
    t_thr(3, IDX_NEG_LIMIT, IDX_NEG_COUNT, IDX_STATUS_LOW, 7, IDX_CLEAR_LOW, 8'h03);
    rd_chk(IDX_NEG_COUNT, 8'h00);
    pulse(1);
    t_thr(2, IDX_LINK_LIMIT, IDX_LINK10_COUNT, IDX_STATUS_LOW, 3, IDX_CLEAR_LOW, 8'h04);
    rd_chk(IDX_LINK10_COUNT, 8'h00);
    rd_chk(IDX_LINK1K_COUNT, 8'h00);
    t_thr(0, IDX_IDLE_LIMIT, IDX_IDLE_COUNT, IDX_STATUS_HIGH, 3, IDX_CLEAR_HIGH, 8'h02);
    $display("test thresholds done");
  endtask : t_counts

  task automatic t_pin();
    wr_reg(IDX_OUT_CONTROL, 8'h04);
    repeat (3) @(posedge sys_clk);
    chk(irq_oe_n, 32'h0);
    chk(irq_pin, 32'h1);
    led_en <= 1'h0;
    repeat (3) @(posedge sys_clk);
    chk(irq_oe_n, 32'h1);
    led_en <= 1'h1;
    wr_reg(IDX_ENABLE_LOW, 8'h00);
    pulse(13);
    chk(irq_pend, 32'h0);
    chk(irq_pin, 32'h1);
    wr_reg(IDX_ENABLE_LOW, 8'h40);
    repeat (3) @(posedge sys_clk);
    chk(irq_pend, 32'h1);
    chk(irq_pin, 32'h0);
    wr_reg(IDX_OUT_CONTROL, 8'h05);
    repeat (3) @(posedge sys_clk);
    chk(irq_pin, 32'h1);
    rd_chk(IDX_OUT_CONTROL, 8'h05);
    wr_reg(IDX_CLEAR_LOW, 8'h40);
    repeat (3) @(posedge sys_clk);
    chk(irq_pin, 32'h0);
    $display("test pin done");
  endtask : t_pin

  // Reset in mid-run restores defaults; events with all enables clear stay off the pin
  task automatic t_rerst();
    @(posedge sys_clk);
    rst_n <= 1'h0;
    repeat (3) @(posedge sys_clk);
    chk(irq_oe_n, 32'h1);
    rst_n <= 1'h1;
    rd_chk(IDX_OUT_CONTROL, 8'h00);
    rd_chk(IDX_NEG_LIMIT, 8'hFF);
    rd_chk(IDX_IDLE_COUNT, 8'h00);
    pulse(13);
    rd_chk(IDX_STATUS_LOW, 8'h40);
    chk(irq_pend, 32'h0);
    $display("test mid-run reset done");
  endtask : t_rerst

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'h1;
    t_reset();
    t_status();
    t_counts();
    t_pin();
    t_rerst();
    end_of_test();
  end
endmodule : phy_irq_ctrl_tb
`default_nettype wire
